// ===== omsm_pkg.sv
// Constants and types for the operating-mode state machine.
// Assumes a 50 MHz core clock.
package omsm_pkg;
    localparam int CLK_MHZ = 50;
    // Times in their own units
    localparam int FILTER_TIME_NS = 2000;
    localparam int WAIT_TIME_US = 300;
    localparam int SMA_TIME_NS = 6000;
    localparam int APD_TIME_NS = 10000;
    localparam int CORE_UP_US = 500;
    // Derived cycle counts
    localparam int FILTER_CYC = FILTER_TIME_NS * CLK_MHZ / 1000;
    localparam int WAIT_CYC = WAIT_TIME_US * CLK_MHZ;
    localparam int SMA_CYC = SMA_TIME_NS * CLK_MHZ / 1000;
    localparam int APD_CYC = APD_TIME_NS * CLK_MHZ / 1000;
    localparam int CORE_UP_CYC = CORE_UP_US * CLK_MHZ;
    localparam int CNT_W = 16;

    typedef enum logic [1:0] {
        OMSM_POWERUP = 2'b00,
        OMSM_NORMAL  = 2'b01,
        OMSM_SLEEP   = 2'b10
    } omsm_mode_e;
endpackage

// ===== omsm_core.sv
// Operating-mode sequencer: power-up, normal, sleep and safe state.
// Assumes sleep_request_pin_n and SPI event strobes synchronous to core_clk.
`timescale 1ns/1ns
module omsm_core
    import omsm_pkg::*;
#(
    parameter int WAIT_COUNT = WAIT_CYC,
    parameter int CORE_UP_COUNT = CORE_UP_CYC
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic logic_supply_ok,
    input wire logic driver_supply_ok,
    input wire logic sleep_request_pin_n,
    input wire logic spi_frame_ok,
    input wire logic spi_mode_change,
    input wire logic spi_clear_config,
    input wire logic wait_restart_opt,
    input wire logic sleep_flag_clear,
    output logic [1:0] mode,
    output logic spi_ready,
    output logic pins_enable,
    output logic core_active,
    output logic pump_en,
    output logic gate_en,
    output logic amp_en,
    output logic watchdog_en,
    output logic monitor_en,
    output logic fault_n_out,
    output logic fault_n_oe,
    output logic sleep_flag,
    output logic err1_latched,
    output logic config_clear
);
    // ----------------------------------------
    // Reset synchroniser and supply reset
    // ----------------------------------------
    logic rst_s1_reg, rst_s2_reg;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end
    wire por_active = !rst_s2_reg || !logic_supply_ok;

    // ----------------------------------------
    // Sleep pin filter
    // ----------------------------------------
    logic pin_filt_reg, pin_filt_next;
    logic [CNT_W-1:0] filt_cnt_reg, filt_cnt_next;
    wire pin_differs = sleep_request_pin_n != pin_filt_reg;
    wire filt_done = filt_cnt_reg == CNT_W'(FILTER_CYC - 1);
    wire fall_det = pin_differs && filt_done && pin_filt_reg;
    wire rise_det = pin_differs && filt_done && !pin_filt_reg;
    assign filt_cnt_next = !pin_differs || filt_done ? '0 :
                           filt_cnt_reg + 1'b1;
    assign pin_filt_next = pin_differs && filt_done ?
                           sleep_request_pin_n : pin_filt_reg;

    // ----------------------------------------
    // Mode state and wait sequence
    // ----------------------------------------
    omsm_mode_e mode_reg, mode_next;
    logic wait_act_reg, wait_act_next;
    logic sma_act_reg, sma_act_next;
    logic [15:0] wait_cnt_reg, wait_cnt_next;
    logic [CNT_W-1:0] sma_cnt_reg, sma_cnt_next;
    logic [CNT_W-1:0] apd_cnt_reg, apd_cnt_next;
    logic [15:0] core_cnt_reg, core_cnt_next;
    logic frame_seen_reg, frame_seen_next;
    logic safe_reg, safe_next;
    logic flag_reg, flag_next;

    wire core_up = core_cnt_reg == 16'(CORE_UP_COUNT - 1);
    wire spi_ok = core_up && logic_supply_ok;
    wire spi_seen = spi_frame_ok && spi_ok;
    wire wait_done = wait_cnt_reg == 16'(WAIT_COUNT - 1);
    wire sma_done = sma_cnt_reg == CNT_W'(SMA_CYC - 1);
    wire apd_done = apd_cnt_reg == CNT_W'(APD_CYC - 1);
    wire apd_run = !pin_filt_reg && !safe_reg && mode_reg != OMSM_SLEEP;
    wire in_sleep = mode_reg == OMSM_SLEEP;
    wire go_normal = mode_reg == OMSM_POWERUP && spi_mode_change &&
                     spi_ok && (frame_seen_reg || spi_frame_ok);
    wire go_powerup = mode_reg == OMSM_NORMAL &&
                      (spi_mode_change || spi_clear_config);

    always_comb begin
        mode_next = mode_reg;
        wait_act_next = wait_act_reg;
        sma_act_next = sma_act_reg;
        wait_cnt_next = wait_act_reg ? wait_cnt_reg + 16'h0001 : 16'h0000;
        sma_cnt_next = sma_act_reg ? sma_cnt_reg + 1'b1 : '0;
        if (fall_det && !in_sleep) begin
            wait_act_next = 1'b1;
            wait_cnt_next = 16'h0000;
        end else if (wait_act_reg && rise_det) begin
            wait_act_next = 1'b0;
        end else if (wait_act_reg && spi_seen) begin
            wait_cnt_next = 16'h0000;
            wait_act_next = wait_restart_opt;
        end else if (wait_act_reg && wait_done) begin
            wait_act_next = 1'b0;
            sma_act_next = 1'b1;
        end
        if (sma_act_reg && sma_done) begin
            sma_act_next = 1'b0;
            mode_next = OMSM_SLEEP;
        end else if (in_sleep && rise_det) begin
            mode_next = OMSM_POWERUP;
        end else if (go_normal) begin
            mode_next = OMSM_NORMAL;
        end else if (go_powerup) begin
            mode_next = OMSM_POWERUP;
        end
    end

    assign apd_cnt_next = apd_run && !apd_done ? apd_cnt_reg + 1'b1 : '0;
    assign safe_next = (apd_run && apd_done) ? 1'b1 :
                       (pin_filt_reg ? 1'b0 : safe_reg);
    assign core_cnt_next = in_sleep ? 16'h0000 :
                           (core_up ? core_cnt_reg : core_cnt_reg + 16'h0001);
    assign frame_seen_next = in_sleep ? 1'b0 : (frame_seen_reg || spi_seen);
    assign flag_next = fall_det ? 1'b1 :
                       (sleep_flag_clear ? 1'b0 : flag_reg);

    // ----------------------------------------
    // Filter registers
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_filt_reg <= 1'b1;
            filt_cnt_reg <= '0;
        end else if (por_active) begin
            pin_filt_reg <= 1'b1;
            filt_cnt_reg <= '0;
        end else begin
            pin_filt_reg <= pin_filt_next;
            filt_cnt_reg <= filt_cnt_next;
        end
    end

    // ----------------------------------------
    // Wait sequence registers
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_act_reg <= 1'b0;
            wait_cnt_reg <= 16'h0000;
        end else if (por_active) begin
            wait_act_reg <= 1'b0;
            wait_cnt_reg <= 16'h0000;
        end else begin
            wait_act_reg <= wait_act_next;
            wait_cnt_reg <= wait_cnt_next;
        end
    end

    // ----------------------------------------
    // Activation delay registers
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sma_act_reg <= 1'b0;
            sma_cnt_reg <= '0;
        end else if (por_active) begin
            sma_act_reg <= 1'b0;
            sma_cnt_reg <= '0;
        end else begin
            sma_act_reg <= sma_act_next;
            sma_cnt_reg <= sma_cnt_next;
        end
    end

    // ----------------------------------------
    // Mode register and core-ready timer
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg <= OMSM_POWERUP;
            core_cnt_reg <= 16'h0000;
        end else if (por_active) begin
            mode_reg <= OMSM_POWERUP;
            core_cnt_reg <= 16'h0000;
        end else begin
            mode_reg <= mode_next;
            core_cnt_reg <= core_cnt_next;
        end
    end

    // ----------------------------------------
    // Discharge registers
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            apd_cnt_reg <= '0;
            safe_reg <= 1'b0;
        end else if (por_active) begin
            apd_cnt_reg <= '0;
            safe_reg <= 1'b0;
        end else begin
            apd_cnt_reg <= apd_cnt_next;
            safe_reg <= safe_next;
        end
    end

    // ----------------------------------------
    // Status registers
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_seen_reg <= 1'b0;
            flag_reg <= 1'b0;
        end else if (por_active) begin
            frame_seen_reg <= 1'b0;
            flag_reg <= 1'b0;
        end else begin
            frame_seen_reg <= frame_seen_next;
            flag_reg <= flag_next;
        end
    end

    // ----------------------------------------
    // Output decode
    // ----------------------------------------
    wire is_normal = mode_next == OMSM_NORMAL && !por_active;
    wire sleep_n = mode_next != OMSM_SLEEP && !por_active;
    wire gates_off = safe_next || !driver_supply_ok;
    wire pin_low_held = !pin_filt_next;
    wire gate_next = is_normal && !gates_off && !wait_act_next &&
                     !pin_low_held;
    wire fault_drive = sleep_n && (mode_next == OMSM_POWERUP ||
                       !driver_supply_ok || wait_act_next);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode <= 2'b00;
            spi_ready <= 1'b0;
            pins_enable <= 1'b0;
            core_active <= 1'b0;
            pump_en <= 1'b0;
            gate_en <= 1'b0;
            amp_en <= 1'b0;
            watchdog_en <= 1'b0;
            monitor_en <= 1'b0;
        end else begin
            mode <= por_active ? OMSM_POWERUP : mode_next;
            spi_ready <= sleep_n && spi_ok;
            pins_enable <= sleep_n;
            core_active <= sleep_n;
            pump_en <= is_normal;
            gate_en <= gate_next;
            amp_en <= is_normal;
            watchdog_en <= is_normal;
            monitor_en <= sleep_n;
        end
    end

    // ----------------------------------------
    // Fault pin and status outputs
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_n_out <= 1'b0;
            fault_n_oe <= 1'b0;
            sleep_flag <= 1'b0;
            err1_latched <= 1'b0;
            config_clear <= 1'b0;
        end else begin
            fault_n_out <= 1'b0;
            fault_n_oe <= fault_drive;
            sleep_flag <= flag_next && !por_active;
            err1_latched <= (flag_next || err1_latched) && !por_active;
            config_clear <= mode_reg == OMSM_NORMAL && spi_clear_config;
        end
    end
endmodule

// ===== omsm_host.sv
// Host model: sleep-request pin and mode-change frames.
// Assumes one clock shared with the sequencer.
`timescale 1ns/1ns
module omsm_host (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic spi_ready,
    input wire logic go,
    input wire logic sleep_low,
    output logic sleep_request_pin_n,
    output logic spi_frame_ok,
    output logic spi_mode_change
);
    logic pend_reg;
    wire send = pend_reg & spi_ready;
    assign sleep_request_pin_n = ~sleep_low;
    // Go request held pending until spi_ready, then one mode-change frame sent
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_reg <= 1'b0;
            spi_frame_ok <= 1'b0;
            spi_mode_change <= 1'b0;
        end else begin
            pend_reg <= go | (pend_reg & ~spi_ready);
            spi_frame_ok <= send;
            spi_mode_change <= send;
        end
    end
endmodule

// ===== omsm_core_chk.sv
// Checker for the mode sequencer ports.
// Assumes binding onto omsm_core.
`timescale 1ns/1ns
module omsm_core_chk #(
    parameter int WAIT_COUNT = 50,
    parameter int CORE_UP_COUNT = 20
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic logic_supply_ok,
    input wire logic driver_supply_ok,
    input wire logic sleep_request_pin_n,
    input wire logic spi_mode_change,
    input wire logic spi_clear_config,
    input wire logic [1:0] mode,
    input wire logic spi_ready,
    input wire logic pins_enable,
    input wire logic core_active,
    input wire logic pump_en,
    input wire logic gate_en,
    input wire logic amp_en,
    input wire logic watchdog_en,
    input wire logic fault_n_oe,
    input wire logic sleep_flag,
    input wire logic err1_latched,
    input wire logic config_clear
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic [7:0] low_cnt;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) low_cnt <= 8'h00;
        else if (sleep_request_pin_n) low_cnt <= 8'h00;
        else if (low_cnt != 8'hFF) low_cnt <= low_cnt + 8'h01;
    end
    property p_norm; mode == 2'b01 |-> pump_en && amp_en && watchdog_en
        && core_active; endproperty
    a_norm: assert property (p_norm) else $error("normal enables");
    property p_sleep; mode == 2'b10 |-> !fault_n_oe && !gate_en && !pump_en;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep outputs");
    property p_pwr; mode != 2'b01 |-> !pump_en && !gate_en; endproperty
    a_pwr: assert property (p_pwr) else $error("power-up outputs");
    property p_err; $rose(sleep_flag) |-> err1_latched; endproperty
    a_err: assert property (p_err) else $error("error latch");
    property p_filt; low_cnt == 8'd110 && logic_supply_ok |-> !gate_en
        && sleep_flag; endproperty
    a_filt: assert property (p_filt) else $error("filtered low");
    property p_uv; core_active && !driver_supply_ok && mode != 2'b10 |=>
        !gate_en && (fault_n_oe || mode == 2'b10); endproperty
    a_uv: assert property (p_uv) else $error("undervoltage");
    property p_lso; !logic_supply_ok |=> !pins_enable && !spi_ready;
    endproperty
    a_lso: assert property (p_lso) else $error("logic supply");
    property p_enter; $rose(mode == 2'b01) |-> $past(spi_mode_change) &&
        $past(spi_ready); endproperty
    a_enter: assert property (p_enter) else $error("normal entry");
    property p_clr; mode == 2'b01 && spi_clear_config |=> mode == 2'b00 &&
        config_clear; endproperty
    a_clr: assert property (p_clr) else $error("clear config");
endmodule
bind omsm_core omsm_core_chk #(.WAIT_COUNT(WAIT_COUNT),
    .CORE_UP_COUNT(CORE_UP_COUNT)) u_chk (.*);

// ===== testbench.sv
// Testbench for the mode sequencer with host model.
// Assumes shortened wait and core-ready counts.
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; \
    $display("Error %0t got %h exp %h", $time, a, b); end end
module testbench;
    import omsm_pkg::*;
    localparam int WC = 300;
    localparam int CU = 20;
    logic core_clk = 0, rst_n = 0, lso = 1, dso = 1, clr = 0, opt = 0;
    logic go = 0, slp = 0;
    wire pin_n, frame, mchg, rdy, pe, ca, pu, ge, am, wd, mo, fo, foe, sf, e1;
    wire cc;
    wire [1:0] mode;
    int fail_count = 0, checks = 0, n;
    omsm_host HOST (.core_clk(core_clk), .rst_n(rst_n), .spi_ready(rdy),
        .go(go), .sleep_low(slp), .sleep_request_pin_n(pin_n),
        .spi_frame_ok(frame), .spi_mode_change(mchg));
    omsm_core #(.WAIT_COUNT(WC), .CORE_UP_COUNT(CU)) DUT (.core_clk(core_clk),
        .rst_n(rst_n), .logic_supply_ok(lso), .driver_supply_ok(dso),
        .sleep_request_pin_n(pin_n), .spi_frame_ok(frame),
        .spi_mode_change(mchg), .spi_clear_config(clr),
        .wait_restart_opt(opt), .sleep_flag_clear(1'b0), .mode(mode),
        .spi_ready(rdy), .pins_enable(pe), .core_active(ca), .pump_en(pu),
        .gate_en(ge), .amp_en(am), .watchdog_en(wd), .monitor_en(mo),
        .fault_n_out(fo), .fault_n_oe(foe), .sleep_flag(sf),
        .err1_latched(e1), .config_clear(cc));
    initial forever #10 core_clk = ~core_clk;
    task automatic cyc(input int k);
        repeat (k) @(posedge core_clk);
    endtask
    function automatic bit filt(input int k);
        return k > FILTER_CYC;
    endfunction
    task automatic to_normal();
        go <= 1'b1;
        cyc(1);
        go <= 1'b0;
        cyc(CU + 10);
    endtask
    task automatic end_sim();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        cyc(20000);
        fail_count++;
        end_sim();
    end
    initial begin
        void'($urandom(32'h6068));
        cyc(5);
        rst_n <= 1'b1;
        opt <= 1'($urandom_range(1, 0));
        cyc(4);
        `CHK(mode, 2'b00)
        `CHK({foe, fo, ca, mo, pu, rdy}, 6'b101100)
        to_normal();
        `CHK(mode, 2'b01)
        `CHK({pu, ge, am, wd, mo}, 5'b11111)
        for (int i = 0; i < 4; i++) begin
            n = $urandom_range(90, 1);
            slp <= 1'b1;
            cyc(n);
            slp <= 1'b0;
            cyc(5);
            `CHK(sf, filt(n))
        end
        $display("test glitches done");
        slp <= 1'b1;
        cyc(FILTER_CYC + 5);
        `CHK({sf, e1, ge, foe, rdy, mode}, 7'b1101101)
        cyc(APD_CYC + WC + SMA_CYC + 20);
        `CHK({mode, foe, pe, ca}, 5'b10000)
        slp <= 1'b0;
        cyc(FILTER_CYC + 5);
        `CHK(mode, 2'b00)
        cyc(CU + 5);
        `CHK(rdy, 1'b1)
        $display("test sleep done");
        to_normal();
        slp <= 1'b1;
        cyc(FILTER_CYC + 20);
        slp <= 1'b0;
        cyc(FILTER_CYC + WC + SMA_CYC + 20);
        `CHK({mode, ge}, 3'b011)
        clr <= 1'b1;
        cyc(1);
        clr <= 1'b0;
        @(negedge core_clk);
        `CHK(cc, 1'b1)
        cyc(2);
        `CHK(mode, 2'b00)
        slp <= 1'b1;
        cyc(FILTER_CYC + 5);
        go <= 1'b1;
        cyc(1);
        go <= 1'b0;
        cyc(10);
        `CHK(ge, 1'b0)
        cyc(WC + SMA_CYC + 60);
        `CHK(mode, opt ? 2'b10 : 2'b01)
        slp <= 1'b0;
        cyc(FILTER_CYC + 5);
        clr <= 1'b1;
        cyc(1);
        clr <= 1'b0;
        cyc(2);
        `CHK(mode, 2'b00)
        $display("test cancel done");
        to_normal();
        dso <= 1'b0;
        cyc(3);
        `CHK({ge, foe}, 2'b01)
        dso <= 1'b1;
        lso <= 1'b0;
        cyc(3);
        `CHK({pe, mode}, 3'b000)
        lso <= 1'b1;
        $display("test supplies done");
        end_sim();
    end
endmodule
